// [verilog/cmac_params.svh]
// Constants of the channel monitor and store align control registers.
// Assumes a byte-wide synchronous control port and a 100 MHz mclk.
`ifndef CMAC_PARAMS_SVH
`define CMAC_PARAMS_SVH

`define CMAC_ADDR_W            8
`define CMAC_DATA_W            8
`define CMAC_CHAN_W            5
`define CMAC_SEP_W             6
`define CMAC_ADDR_LB_TXMON     8'hA8
`define CMAC_ADDR_ALIGN_RXMON  8'hAA
`define CMAC_RLB_BIT           7
`define CMAC_RX_ALIGN_BIT      6
`define CMAC_TX_ALIGN_BIT      5
`define CMAC_CHAN_MSB          4
`define CMAC_CHAN_LSB          0
`define CMAC_REG_RESET         8'h00
`define CMAC_HALF_FRAME        6'h10
`define CMAC_READ_IDLE         8'h00

`endif

// [verilog/cmac_pkg.sv]
// Types of the channel monitor and store align control block.
// Assumes cmac_params.svh is on the include path.
`default_nettype none
`include "cmac_params.svh"

package cmac_pkg;
    typedef struct packed {
        logic                     prev_cmd;
        logic                     pulse;
    } cmac_align_st_t;

    typedef struct packed {
        logic [`CMAC_DATA_W-1:0]  lb_txmon;
        logic [`CMAC_DATA_W-1:0]  align_rxmon;
        logic [`CMAC_DATA_W-1:0]  rdata;
        logic [`CMAC_DATA_W-1:0]  tx_mon;
        logic [`CMAC_DATA_W-1:0]  rx_mon;
    } cmac_ctrl_st_t;
endpackage : cmac_pkg

`default_nettype wire

// [verilog/cmac_edge_align.sv]
// Rising-edge align command for one elastic store.
// Assumes the store reports its write/read pointer separation in bytes on mclk.
`default_nettype none
`include "cmac_params.svh"

module cmac_edge_align (
    input  wire logic                   mclk,
    input  wire logic                   resetn,
    input  wire logic                   align_cmd,
    input  wire logic [`CMAC_SEP_W-1:0] store_sep,
    output logic                        align_pulse
);
    import cmac_pkg::*;

    cmac_align_st_t st;
    cmac_align_st_t next_st;

    always_comb begin
        next_st          = st;
        next_st.prev_cmd = align_cmd;
        // Only a fresh rise acts, and only on a store that is too close
        next_st.pulse    = align_cmd && !st.prev_cmd
                           && (store_sep < `CMAC_HALF_FRAME);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign align_pulse = st.pulse;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_rise_acts;
        align_cmd && !st.prev_cmd && (store_sep < `CMAC_HALF_FRAME) |=> align_pulse;
    endproperty
    a_rise_acts: assert property (p_rise_acts) else $error("align rise ignored");

    property p_far_store_kept;
        store_sep >= `CMAC_HALF_FRAME |=> !align_pulse;
    endproperty
    a_far_store_kept: assert property (p_far_store_kept)
        else $error("far store disturbed");

    sequence s_held_high;
        align_cmd [*2];
    endsequence
    property p_held_no_repeat;
        s_held_high |=> !align_pulse;
    endproperty
    a_held_no_repeat: assert property (p_held_no_repeat)
        else $error("held bit realigned");

endmodule : cmac_edge_align

`default_nettype wire

// [verilog/cmac_top.sv]
// Loopback, channel monitor select and elastic store align control registers.
// Assumes a synchronous byte-wide control port on mclk; reads answer one cycle later.
//
// Function
// - Remote loopback is enabled exactly while its control bit is one.
// - Five-bit transmit field picks the channel copied into transmit monitor.
// - Five-bit receive field picks the channel copied into receive monitor.
// - Receive align rise forces close receive store pointers half a frame apart.
// - Transmit align rise forces close transmit store pointers half a frame apart.
// - A store already half a frame apart is left untouched on align.
// - Only a zero-to-one transition aligns; held-high bit does nothing more.
`default_nettype none
`include "cmac_params.svh"

module cmac_top (
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    input  wire logic                      wr_en,
    input  wire logic                      rd_en,
    input  wire logic [`CMAC_ADDR_W-1:0]   addr,
    input  wire logic [`CMAC_DATA_W-1:0]   wdata,
    output logic      [`CMAC_DATA_W-1:0]   rdata,
    input  wire logic                      tx_chan_valid,
    input  wire logic [`CMAC_CHAN_W-1:0]   tx_chan_num,
    input  wire logic [`CMAC_DATA_W-1:0]   tx_chan_data,
    input  wire logic                      rx_chan_valid,
    input  wire logic [`CMAC_CHAN_W-1:0]   rx_chan_num,
    input  wire logic [`CMAC_DATA_W-1:0]   rx_chan_data,
    input  wire logic [`CMAC_SEP_W-1:0]    rx_store_sep,
    input  wire logic [`CMAC_SEP_W-1:0]    tx_store_sep,
    output logic                           remote_loopback_en,
    output logic      [`CMAC_CHAN_W-1:0]   tx_monitor_chan,
    output logic      [`CMAC_CHAN_W-1:0]   rx_monitor_chan,
    output logic      [`CMAC_DATA_W-1:0]   tx_channel_monitor_reg,
    output logic      [`CMAC_DATA_W-1:0]   rx_channel_monitor_reg,
    output logic                           rx_store_align_pulse,
    output logic                           tx_store_align_pulse
);
    import cmac_pkg::*;

    cmac_ctrl_st_t st;
    cmac_ctrl_st_t next_st;

    logic wr_lb;
    logic wr_al;
    logic rx_store_align_cmd;
    logic tx_store_align_cmd;

    assign wr_lb = wr_en && (addr == `CMAC_ADDR_LB_TXMON);
    assign wr_al = wr_en && (addr == `CMAC_ADDR_ALIGN_RXMON);

    always_comb begin
        next_st = st;
        // Whole byte is stored; the host keeps unassigned bits at zero
        if (wr_lb) begin
            next_st.lb_txmon = wdata;
        end
        if (wr_al) begin
            next_st.align_rxmon = wdata;
        end
        if (rd_en) begin
            unique case (addr)
                `CMAC_ADDR_LB_TXMON:    next_st.rdata = st.lb_txmon;
                `CMAC_ADDR_ALIGN_RXMON: next_st.rdata = st.align_rxmon;
                default:                next_st.rdata = `CMAC_READ_IDLE;
            endcase
        end
        // Monitor registers copy the selected channel byte as it passes
        if (tx_chan_valid
            && tx_chan_num == st.lb_txmon[`CMAC_CHAN_MSB:`CMAC_CHAN_LSB]) begin
            next_st.tx_mon = tx_chan_data;
        end
        if (rx_chan_valid
            && rx_chan_num == st.align_rxmon[`CMAC_CHAN_MSB:`CMAC_CHAN_LSB]) begin
            next_st.rx_mon = rx_chan_data;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st.lb_txmon    <= `CMAC_REG_RESET;
            st.align_rxmon <= `CMAC_REG_RESET;
            st.rdata       <= `CMAC_READ_IDLE;
            st.tx_mon      <= `CMAC_REG_RESET;
            st.rx_mon      <= `CMAC_REG_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign rx_store_align_cmd     = st.align_rxmon[`CMAC_RX_ALIGN_BIT];
    assign tx_store_align_cmd     = st.align_rxmon[`CMAC_TX_ALIGN_BIT];
    assign rdata                  = st.rdata;
    assign remote_loopback_en     = st.lb_txmon[`CMAC_RLB_BIT];
    assign tx_monitor_chan        = st.lb_txmon[`CMAC_CHAN_MSB:`CMAC_CHAN_LSB];
    assign rx_monitor_chan        = st.align_rxmon[`CMAC_CHAN_MSB:`CMAC_CHAN_LSB];
    assign tx_channel_monitor_reg = st.tx_mon;
    assign rx_channel_monitor_reg = st.rx_mon;

    // One align unit per elastic store
    cmac_edge_align u_rx_align (
        .mclk        (mclk),
        .resetn      (resetn),
        .align_cmd   (rx_store_align_cmd),
        .store_sep   (rx_store_sep),
        .align_pulse (rx_store_align_pulse)
    );

    cmac_edge_align u_tx_align (
        .mclk        (mclk),
        .resetn      (resetn),
        .align_cmd   (tx_store_align_cmd),
        .store_sep   (tx_store_sep),
        .align_pulse (tx_store_align_pulse)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_loopback_set;
        wr_lb |=> remote_loopback_en == $past(wdata[`CMAC_RLB_BIT]);
    endproperty
    a_loopback_set: assert property (p_loopback_set) else $error("loopback not written");

    property p_loopback_hold;
        !wr_lb |=> $stable(remote_loopback_en);
    endproperty
    a_loopback_hold: assert property (p_loopback_hold) else $error("loopback moved");

    property p_tx_select;
        wr_lb |=> tx_monitor_chan == $past(wdata[`CMAC_CHAN_MSB:`CMAC_CHAN_LSB]);
    endproperty
    a_tx_select: assert property (p_tx_select) else $error("tx channel select wrong");

    property p_rx_select;
        wr_al |=> rx_monitor_chan == $past(wdata[`CMAC_CHAN_MSB:`CMAC_CHAN_LSB]);
    endproperty
    a_rx_select: assert property (p_rx_select) else $error("rx channel select wrong");

    property p_tx_capture;
        tx_chan_valid && tx_chan_num == tx_monitor_chan
            |=> tx_channel_monitor_reg == $past(tx_chan_data);
    endproperty
    a_tx_capture: assert property (p_tx_capture) else $error("tx monitor missed byte");

    property p_tx_no_capture;
        !(tx_chan_valid && tx_chan_num == tx_monitor_chan) |=> $stable(tx_channel_monitor_reg);
    endproperty
    a_tx_no_capture: assert property (p_tx_no_capture)
        else $error("tx monitor wrong byte");

    property p_rx_no_capture;
        !(rx_chan_valid && rx_chan_num == rx_monitor_chan) |=> $stable(rx_channel_monitor_reg);
    endproperty
    a_rx_no_capture: assert property (p_rx_no_capture)
        else $error("rx monitor wrong byte");

    property p_tx_select_hold;
        !wr_lb |=> $stable(tx_monitor_chan);
    endproperty
    a_tx_select_hold: assert property (p_tx_select_hold)
        else $error("tx channel select moved");

    property p_rx_select_hold;
        !wr_al |=> $stable(rx_monitor_chan);
    endproperty
    a_rx_select_hold: assert property (p_rx_select_hold)
        else $error("rx channel select moved");

    property p_rx_capture;
        rx_chan_valid && rx_chan_num == rx_monitor_chan
            |=> rx_channel_monitor_reg == $past(rx_chan_data);
    endproperty
    a_rx_capture: assert property (p_rx_capture) else $error("rx monitor missed byte");

    property p_readback;
        rd_en && addr == `CMAC_ADDR_ALIGN_RXMON |=> rdata == $past(st.align_rxmon);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    property p_lb_readback;
        rd_en && addr == `CMAC_ADDR_LB_TXMON |=> rdata == $past(st.lb_txmon);
    endproperty
    a_lb_readback: assert property (p_lb_readback)
        else $error("loopback readback mismatch");

    // Unmapped addresses read as the idle byte
    property p_unmapped_read;
        rd_en && addr != `CMAC_ADDR_LB_TXMON && addr != `CMAC_ADDR_ALIGN_RXMON
            |=> rdata == `CMAC_READ_IDLE;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not idle");

    property p_rdata_hold;
        !rd_en |=> $stable(rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without read");

    sequence s_rx_align_write;
        wr_al && wdata[`CMAC_RX_ALIGN_BIT] && !rx_store_align_cmd;
    endsequence
    sequence s_rx_close_store;
        ##1 (rx_store_sep < `CMAC_HALF_FRAME);
    endsequence
    property p_rx_align_path;
        s_rx_align_write ##0 s_rx_close_store |=> rx_store_align_pulse;
    endproperty
    a_rx_align_path: assert property (p_rx_align_path) else $error("rx align lost");

    sequence s_tx_align_write;
        wr_en && addr == `CMAC_ADDR_ALIGN_RXMON && wdata[`CMAC_TX_ALIGN_BIT]
            && !tx_store_align_cmd;
    endsequence
    sequence s_tx_close_store;
        ##1 (tx_store_sep < `CMAC_HALF_FRAME);
    endsequence
    property p_tx_align_path;
        s_tx_align_write ##0 s_tx_close_store |=> tx_store_align_pulse;
    endproperty
    a_tx_align_path: assert property (p_tx_align_path) else $error("tx align lost");

    property p_align_needs_rise;
        rx_store_align_pulse |-> $past(rx_store_align_cmd) && !$past(rx_store_align_cmd, 2);
    endproperty
    a_align_needs_rise: assert property (p_align_needs_rise)
        else $error("align without rise");

    property p_tx_align_needs_rise;
        tx_store_align_pulse |-> $past(tx_store_align_cmd) && !$past(tx_store_align_cmd, 2);
    endproperty
    a_tx_align_needs_rise: assert property (p_tx_align_needs_rise)
        else $error("tx align without rise");

    // A store is told to realign once per rise, never twice in a row
    property p_rx_pulse_single;
        rx_store_align_pulse |=> !rx_store_align_pulse;
    endproperty
    a_rx_pulse_single: assert property (p_rx_pulse_single)
        else $error("rx align pulse too long");

    property p_tx_pulse_single;
        tx_store_align_pulse |=> !tx_store_align_pulse;
    endproperty
    a_tx_pulse_single: assert property (p_tx_pulse_single)
        else $error("tx align pulse too long");

endmodule : cmac_top

`default_nettype wire

// [tb/cmac_host_model.sv]
// Host model: byte-wide strobe master of the control port.
// Assumes the bench calls wr and rd hierarchically, one at a time.
`default_nettype none
`include "cmac_params.svh"

module cmac_host_model (
    input  wire logic                    mclk,
    output var  logic                    wr_en,
    output var  logic                    rd_en,
    output var  logic [`CMAC_ADDR_W-1:0] addr,
    output var  logic [`CMAC_DATA_W-1:0] wdata,
    input  wire logic [`CMAC_DATA_W-1:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr  = 8'h00;
        wdata = 8'h00;
    end

    // Unassigned bits of the two mapped registers go out as zero; other addresses pass all bits
    function automatic logic [7:0] keep_mask(input logic [7:0] a);
        return (a == `CMAC_ADDR_LB_TXMON) ? 8'h9F :
               (a == `CMAC_ADDR_ALIGN_RXMON) ? 8'h7F : 8'hFF;
    endfunction : keep_mask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        wr_en = 1'b1;
        addr  = a;
        wdata = d & keep_mask(a);
        @(posedge mclk);
        #1;
        wr_en = 1'b0;
        addr  = ~addr;
        wdata = ~wdata;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge mclk);
        #1;
        rd_en = 1'b1;
        addr  = a;
        @(posedge mclk);
        #1;
        rd_en = 1'b0;
        addr  = ~addr;
        q     = rdata;
    endtask : rd
endmodule : cmac_host_model

`default_nettype wire

// [tb/cmac_top_tb_top.sv]
// Self-checking bench of cmac_top: registers, channel monitors, align pulses.
// Assumes cmac_host_model drives the control port; other inputs are driven here.
`default_nettype none
`include "cmac_params.svh"

module cmac_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

    logic       mclk, resetn, wr_en, rd_en, tx_chan_valid, rx_chan_valid;
    logic       remote_loopback_en, rx_store_align_pulse, tx_store_align_pulse;
    logic [7:0] addr, wdata, rdata, tx_chan_data, rx_chan_data, q;
    logic [7:0] tx_channel_monitor_reg, rx_channel_monitor_reg;
    logic [4:0] tx_chan_num, rx_chan_num, tx_monitor_chan, rx_monitor_chan;
    logic [5:0] rx_store_sep, tx_store_sep;
    int         miscompares, checks_done, rx_pulses, tx_pulses;

    cmac_top u_dut (
        .mclk, .resetn, .wr_en, .rd_en, .addr, .wdata, .rdata,
        .tx_chan_valid, .tx_chan_num, .tx_chan_data,
        .rx_chan_valid, .rx_chan_num, .rx_chan_data, .rx_store_sep, .tx_store_sep,
        .remote_loopback_en, .tx_monitor_chan, .rx_monitor_chan,
        .tx_channel_monitor_reg, .rx_channel_monitor_reg,
        .rx_store_align_pulse, .tx_store_align_pulse
    );
    cmac_host_model u_host (.mclk, .wr_en, .rd_en, .addr, .wdata, .rdata);

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    // Every cycle not low counts, so an unknown pulse cannot pass as none
    always @(posedge mclk) begin
        if (rx_store_align_pulse !== 1'b0) rx_pulses <= rx_pulses + 1;
        if (tx_store_align_pulse !== 1'b0) tx_pulses <= tx_pulses + 1;
    end

    task automatic tally_and_finish();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, q);
        `CHK(q, e)
    endtask : chk_rd

    // One byte on both channel buses; receive carries the inverted byte
    task automatic feed(input logic v, input logic [4:0] n, input logic [7:0] d);
        @(posedge mclk);
        #1;
        tx_chan_valid = v;
        rx_chan_valid = v;
        tx_chan_num   = n;
        rx_chan_num   = n;
        tx_chan_data  = d;
        rx_chan_data  = ~d;
        @(posedge mclk);
        #1;
        tx_chan_valid = 1'b0;
        rx_chan_valid = 1'b0;
        tx_chan_data  = ~tx_chan_data;
        rx_chan_data  = ~rx_chan_data;
    endtask : feed

    // Pre-write never raises a bit, so only the second write may align
    task automatic align(input logic [5:0] sep, input logic [7:0] pre, on,
                         input int ex_rx, input int ex_tx);
        int r0;
        int t0;
        rx_store_sep = sep;
        tx_store_sep = sep;
        u_host.wr(8'hAA, pre);
        r0 = rx_pulses;
        t0 = tx_pulses;
        u_host.wr(8'hAA, on);
        repeat (4) @(posedge mclk);
        #1;
        `CHK(rx_pulses - r0, ex_rx)
        `CHK(tx_pulses - t0, ex_tx)
        `CHK({rx_store_align_pulse, tx_store_align_pulse}, 2'h0)
    endtask : align

    // Hang guard well beyond the full sequence
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        resetn        = 1'b0;
        tx_chan_valid = 1'b0;
        rx_chan_valid = 1'b0;
        tx_chan_num   = 5'h00;
        rx_chan_num   = 5'h00;
        tx_chan_data  = 8'h00;
        rx_chan_data  = 8'h00;
        rx_store_sep  = 6'h00;
        tx_store_sep  = 6'h00;
        repeat (6) @(posedge mclk);
        #1;
        resetn = 1'b1;
        `CHK({remote_loopback_en, tx_monitor_chan, rx_monitor_chan}, 11'h000)
        chk_rd(8'hA8, 8'h00);
        chk_rd(8'hAA, 8'h00);
        u_host.wr(8'hA8, 8'h83);
        `CHK({remote_loopback_en, tx_monitor_chan}, 6'h23)
        chk_rd(8'hA8, 8'h83);
        u_host.wr(8'hA9, 8'hFF);
        chk_rd(8'hA9, 8'h00);
        u_host.wr(8'hA8, 8'h1F);
        `CHK({remote_loopback_en, tx_monitor_chan}, 6'h1F)
        chk_rd(8'hA8, 8'h1F);
        u_host.wr(8'hAA, 8'h07);
        `CHK(rx_monitor_chan, 5'h07)
        feed(1'b1, 5'h1F, 8'h5A);
        feed(1'b1, 5'h07, 8'h3C);
        feed(1'b0, 5'h1F, 8'h11);
        feed(1'b1, 5'h1E, 8'h22);
        `CHK(tx_channel_monitor_reg, 8'h5A)
        `CHK(rx_channel_monitor_reg, 8'hC3)
        // Align bits toggle only long after reset, with mclk stable
        align(6'h04, 8'h07, 8'h47, 1, 0);
        align(6'h04, 8'h47, 8'h47, 0, 0);
        align(6'h10, 8'h07, 8'h47, 0, 0);
        align(6'h0F, 8'h07, 8'h27, 0, 1);
        align(6'h0F, 8'h27, 8'h67, 1, 0);
        align(6'h10, 8'h07, 8'h67, 0, 0);
        align(6'h00, 8'h07, 8'h67, 1, 1);
        chk_rd(8'hAA, 8'h67);
        // Reset in mid-run clears registers, monitors and read data
        @(posedge mclk);
        #1;
        resetn = 1'b0;
        @(posedge mclk);
        #1;
        resetn = 1'b1;
        `CHK({remote_loopback_en, tx_monitor_chan, rx_monitor_chan}, 11'h000)
        `CHK({tx_channel_monitor_reg, rx_channel_monitor_reg, rdata}, 24'h000000)
        chk_rd(8'hA8, 8'h00);
        align(6'h00, 8'h07, 8'h47, 1, 0);
        tally_and_finish();
    end
endmodule : cmac_top_tb_top

`default_nettype wire
